// ==== drd_cpu_model.sv ====
// processor address phase: strobes one address onto the muxed bus.
// assumes go is a one-cycle request spaced by at least three cycles.
`timescale 1ns/100ps
module drd_cpu_model (
  // clock
  input wire       mclk,
  // request from bench
  input wire       go,
  input wire [7:0] addrIn,
  // muxed bus, address phase
  output reg [7:0] muxAddrDataBus,
  output reg       addressStrobeN
);
  reg [1:0] phase_ff;
  initial begin
    muxAddrDataBus = 8'h00;
    addressStrobeN = 1'b1;
    phase_ff = 2'h0;
  end
  always @(posedge mclk) begin
    if (go) begin
      muxAddrDataBus <= addrIn;
      addressStrobeN <= 1'b0;
      phase_ff <= 2'h1;
    end else if (phase_ff == 2'h1) begin
      addressStrobeN <= 1'b1; // address held through strobe rise
      phase_ff <= 2'h2;
    end else if (phase_ff == 2'h2) begin
      muxAddrDataBus <= ~muxAddrDataBus; // released bus must not look valid
      phase_ff <= 2'h0;
    end
  end
endmodule

// ==== drd_reg_decoder.v ====
// register address decoder for a two-channel serial controller.
// assumes inputs synchronous to mclk; the bus master holds the latched
// address steady while a wishbone access to the data window is open.
//
// Register access over Wishbone and the register offsets were left to the implementer.
`timescale 1ns/100ps
`include "drd_reg_map.vh"

module drd_reg_decoder (
  // clock and reset
  input  wire        mclk,
  input  wire        rst_n,
  // multiplexed processor bus, address phase
  input  wire [7:0]  muxAddrDataBus,
  input  wire        addressStrobeN,
  // wishbone slave
  input  wire [7:0]  wb_adr_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  input  wire        wb_we_i,
  input  wire [3:0]  wb_sel_i,
  input  wire        wb_stb_i,
  input  wire        wb_cyc_i,
  output wire        wb_ack_o,
  // read-register source from channel logic
  output reg         statusRdChan,
  output reg  [3:0]  statusRdIdx,
  input  wire [7:0]  statusRdData,
  // transmit buffer
  output reg         txStrobe,
  output reg         txChan,
  output reg  [7:0]  txData,
  // configuration to channel logic
  output reg         shiftLeftMode,
  output wire [1:0]  statusFifoEnable,
  output wire [1:0]  extReadEnable
);

  localparam ST_IDLE   = 3'h1;
  localparam ST_SETTLE = 3'h2;
  localparam ST_ACK    = 3'h4;

  // read source codes: status path, stored write register, options copy
  localparam [1:0] SRC_STAT = 2'h0;
  localparam [1:0] SRC_WR   = 2'h2;
  localparam [1:0] SRC_OPT  = 2'h3;

  // forms {channel, index} from a latched address
  function [4:0] decodeAddr;
    input [7:0] addr;
    input       highChan;
    begin
      if (highChan) begin
        decodeAddr = {addr[`DRD_AD_CHAN_HI], addr[`DRD_AD_IDX_MSB:`DRD_AD_IDX_LSB]};
      end else begin
        decodeAddr = {addr[`DRD_AD_CHAN_LO], addr[`DRD_AD_IDX_MSB:`DRD_AD_IDX_LSB]};
      end
    end
  endfunction

  // storage slot; shared registers always use the channel B slot
  function [4:0] memSlot;
    input       chan;
    input [3:0] idx;
    begin
      if (idx == `DRD_IDX_VEC || idx == `DRD_IDX_MIC) begin
        memSlot = {`DRD_CH_B, idx};
      end else begin
        memSlot = {chan, idx};
      end
    end
  endfunction

  // picks the channel A or channel B copy of a per-channel byte
  function [7:0] byChan;
    input       chan;
    input [7:0] copyA;
    input [7:0] copyB;
    begin
      if (chan == `DRD_CH_A) begin
        byChan = copyA;
      end else begin
        byChan = copyB;
      end
    end
  endfunction

  // backward-compatible image index, four below the addressed one
  function [3:0] imageOf;
    input [3:0] idx;
    begin
      imageOf = idx - `DRD_IDX_IMG_OFS;
    end
  endfunction

  // read alias: {from write register, from options register, index}
  function [5:0] readSource;
    input [3:0] idx;
    input       fifoEn;
    input       xrdEn;
    reg         both;
    begin
      both = fifoEn & xrdEn;
      readSource = {SRC_STAT, idx};
      case (idx)
        `DRD_IDX_MODE4, `DRD_IDX_MODE5: begin
          if (both) begin
            readSource = {SRC_WR, idx};
          end else begin
            readSource = {SRC_STAT, imageOf(idx)};
          end
        end
        `DRD_IDX_CNTLO, `DRD_IDX_CNTHI: begin
          if (fifoEn) begin
            readSource = {SRC_STAT, idx};
          end else begin
            readSource = {SRC_STAT, imageOf(idx)};
          end
        end
        `DRD_IDX_MIC: begin
          if (both) begin
            readSource = {SRC_WR, `DRD_IDX_RXPAR};
          end else begin
            readSource = {SRC_STAT, `DRD_IDX_TCHI};
          end
        end
        `DRD_IDX_ALT11: begin
          if (both) begin
            readSource = {SRC_WR, `DRD_IDX_MISC};
          end else begin
            readSource = {SRC_STAT, `DRD_IDX_EXTST};
          end
        end
        `DRD_IDX_OPTRD: begin
          if (both) begin
            readSource = {SRC_OPT, idx};
          end
        end
        default: begin
          readSource = {SRC_STAT, idx};
        end
      endcase
    end
  endfunction

  // read words carry one byte; the upper lanes always read zero
  function [31:0] busWord;
    input [7:0] b;
    begin
      busWord = {24'h000000, b};
    end
  endfunction

  // address capture
  reg  [7:0] latchedAddr_ff;
  reg        strobePrev_ff;

  always @(posedge mclk) begin
    if (!rst_n) begin
      latchedAddr_ff <= `DRD_RST_BYTE;
      strobePrev_ff  <= 1'b1;
    end else begin
      strobePrev_ff <= addressStrobeN;
      if (addressStrobeN && !strobePrev_ff) begin
        latchedAddr_ff <= muxAddrDataBus;
      end
    end
  end

  // decoded access
  wire [4:0] decoded = decodeAddr(latchedAddr_ff, shiftLeftMode);
  wire       selChan = decoded[4];
  wire [3:0] selIdx  = decoded[3:0];

  // per-channel control copies, bit 1 = channel A, bit 0 = channel B
  reg  [7:0] extStatCtlA_ff;
  reg  [7:0] extStatCtlB_ff;
  reg  [7:0] extOptA_ff;
  reg  [7:0] extOptB_ff;

  wire [7:0] selExtStat = byChan(selChan, extStatCtlA_ff, extStatCtlB_ff);
  wire [7:0] selExtOpt  = byChan(selChan, extOptA_ff, extOptB_ff);

  assign statusFifoEnable = {extStatCtlA_ff[`DRD_BIT_FIFO_EN], extStatCtlB_ff[`DRD_BIT_FIFO_EN]};
  assign extReadEnable    = {extOptA_ff[`DRD_BIT_XRD_EN], extOptB_ff[`DRD_BIT_XRD_EN]};

  wire [5:0] source = readSource(selIdx, selExtStat[`DRD_BIT_FIFO_EN],
                                 selExtOpt[`DRD_BIT_XRD_EN]);
  wire       srcWrite = source[5];
  wire       srcOpt   = source[4];
  wire [3:0] srcIdx   = source[3:0];

  // read register pointer handed to the channel logic
  always @(posedge mclk) begin
    if (!rst_n) begin
      statusRdChan <= `DRD_CH_B;
      statusRdIdx  <= `DRD_RST_IDX;
    end else begin
      statusRdChan <= selChan;
      statusRdIdx  <= srcIdx;
    end
  end

  // wishbone handshake: idle, settle one cycle for read data, then ack
  reg  [2:0] state_ff;
  reg  [2:0] nxt_state;
  wire       busReq = wb_cyc_i & wb_stb_i;

  always @* begin
    case (state_ff)
      ST_IDLE: begin
        nxt_state = busReq ? ST_SETTLE : ST_IDLE;
      end
      ST_SETTLE: begin
        nxt_state = busReq ? ST_ACK : ST_IDLE;
      end
      ST_ACK: begin
        nxt_state = ST_IDLE;
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always @(posedge mclk) begin
    if (!rst_n) begin
      state_ff <= ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // an access dropped by the master must never see a late ack
  assign wb_ack_o = (state_ff == ST_ACK) & busReq;

  // write takes effect at the edge where the master samples ack
  wire       wrCommit = wb_ack_o & busReq & wb_we_i & wb_sel_i[0];
  wire       dataWr   = wrCommit && (wb_adr_i == `DRD_OFS_DATA);
  wire [7:0] wrByte   = wb_dat_i[7:0];
  wire       optGate  = selExtStat[`DRD_BIT_OPT_GATE];
  wire       optWr    = dataWr && (selIdx == `DRD_IDX_CNTHI) && optGate;
  wire       extStWr  = dataWr && (selIdx == `DRD_IDX_EXTST);
  wire       memWr    = dataWr && !optWr && !extStWr;
  wire       modeCmd  = dataWr && (selIdx == `DRD_IDX_CMD) && (selChan == `DRD_CH_B);
  wire       txWr     = dataWr && (selIdx == `DRD_IDX_TXBUF);

  // options register and status-control copies
  always @(posedge mclk) begin
    if (!rst_n) begin
      extStatCtlA_ff <= `DRD_RST_BYTE;
      extStatCtlB_ff <= `DRD_RST_BYTE;
      extOptA_ff     <= `DRD_RST_BYTE;
      extOptB_ff     <= `DRD_RST_BYTE;
    end else begin
      if (extStWr && selChan == `DRD_CH_A) begin
        extStatCtlA_ff <= wrByte;
      end
      if (extStWr && selChan == `DRD_CH_B) begin
        extStatCtlB_ff <= wrByte;
      end
      if (optWr && selChan == `DRD_CH_A) begin
        extOptA_ff <= wrByte;
      end
      if (optWr && selChan == `DRD_CH_B) begin
        extOptB_ff <= wrByte;
      end
    end
  end

  // decoding mode: only a command code in channel B moves it
  always @(posedge mclk) begin
    if (!rst_n) begin
      shiftLeftMode <= `DRD_RST_MODE;
    end else if (modeCmd) begin
      case (wrByte[`DRD_CMD_MSB:`DRD_CMD_LSB])
        `DRD_CMD_LOWCH: begin
          shiftLeftMode <= 1'b0;
        end
        `DRD_CMD_HIGHCH: begin
          shiftLeftMode <= 1'b1;
        end
        default: begin
          shiftLeftMode <= shiftLeftMode;
        end
      endcase
    end
  end

  // transmit buffer hand-off, one pulse per write
  always @(posedge mclk) begin
    if (!rst_n) begin
      txStrobe <= 1'b0;
      txChan   <= `DRD_CH_B;
      txData   <= `DRD_RST_BYTE;
    end else begin
      txStrobe <= txWr;
      if (txWr) begin
        txChan <= selChan;
        txData <= wrByte;
      end
    end
  end

  // write-register storage, read port follows the alias source
  wire [7:0] memRdData;

  drd_reg_mem u_mem (
    .mclk      (mclk),
    .rst_n     (rst_n),
    .wrEn      (memWr),
    .wrAddr    (memSlot(selChan, selIdx)),
    .wrData    (wrByte),
    .rdAddr    (memSlot(selChan, srcIdx)),
    .rdData_ff (memRdData)
  );

  // read-back image of the selected location
  wire [7:0] dataImage = srcWrite ? (srcOpt ? selExtOpt : memRdData) : statusRdData;

  wire [7:0] ctrlImage;
  assign ctrlImage[`DRD_CTL_MODE] = shiftLeftMode;
  assign ctrlImage[`DRD_CTL_CHAN] = selChan;
  assign ctrlImage[`DRD_CTL_IDX_MSB:`DRD_CTL_IDX_LSB] = selIdx;
  assign ctrlImage[`DRD_CTL_FIFO] = selExtStat[`DRD_BIT_FIFO_EN];
  assign ctrlImage[`DRD_CTL_XRD]  = selExtOpt[`DRD_BIT_XRD_EN];

  // read data loaded as ack rises; unmapped offsets read zero
  always @(posedge mclk) begin
    if (!rst_n) begin
      wb_dat_o <= `DRD_RST_WORD;
    end else if (state_ff == ST_SETTLE && busReq) begin
      case (wb_adr_i)
        `DRD_OFS_ADDR: begin
          wb_dat_o <= busWord(latchedAddr_ff);
        end
        `DRD_OFS_DATA: begin
          wb_dat_o <= busWord(dataImage);
        end
        `DRD_OFS_CTRL: begin
          wb_dat_o <= busWord(ctrlImage);
        end
        default: begin
          wb_dat_o <= `DRD_RST_WORD;
        end
      endcase
    end
  end

endmodule

// ==== drd_reg_decoder_props.sv ====
// assertion checker for the register decoder's bus-side ports.
// assumes it is bound to drd_reg_decoder; one mclk domain.
`timescale 1ns/100ps
module drd_reg_decoder_props (
  // clock and reset
  input wire        mclk,
  input wire        rst_n,
  // wishbone
  input wire [7:0]  wb_adr_i,
  input wire [31:0] wb_dat_o,
  input wire        wb_we_i,
  input wire        wb_stb_i,
  input wire        wb_cyc_i,
  input wire        wb_ack_o,
  // configuration outputs
  input wire        txStrobe,
  input wire        shiftLeftMode,
  input wire [1:0]  statusFifoEnable,
  input wire [1:0]  extReadEnable
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held more than one cycle");
  ack_latency_a: assert property ($rose(wb_cyc_i && wb_stb_i) |-> ##2 wb_ack_o)
    else $error("ack not two edges after request");
  ack_in_req_a: assert property (wb_ack_o |-> wb_cyc_i && wb_stb_i)
    else $error("ack without open request");
  // reset itself is the antecedent, so no disable here
  reset_state_a: assert property (disable iff (1'b0) !rst_n |=> shiftLeftMode
    && statusFifoEnable == 2'h0 && extReadEnable == 2'h0 && !wb_ack_o)
    else $error("wrong state after reset");
  tx_pulse_a: assert property (txStrobe |=> !txStrobe)
    else $error("transmit strobe longer than one cycle");
  tx_cause_a: assert property (txStrobe |-> $past(wb_ack_o && wb_we_i && wb_adr_i == 8'h04))
    else $error("transmit strobe without data write");
  // reset also moves these; the edge after a reset edge is not a write
  mode_by_cmd_a: assert property ($changed(shiftLeftMode) && $past(rst_n)
    |-> $past(wb_ack_o && wb_we_i))
    else $error("mode changed without a write");
  fifo_by_write_a: assert property ($changed(statusFifoEnable) && $past(rst_n)
    |-> $past(wb_ack_o && wb_we_i))
    else $error("fifo enable changed without a write");
  xrd_by_write_a: assert property ($changed(extReadEnable) && $past(rst_n)
    |-> $past(wb_ack_o && wb_we_i))
    else $error("extended read changed without a write");
  rd_upper_zero_a: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  cover property (wb_ack_o && wb_we_i);
  cover property (txStrobe);
  cover property ($fell(shiftLeftMode));
  cover property ($rose(extReadEnable[1]));
endmodule

// ==== drd_reg_map.vh ====
// named offsets, indices, bit positions and reset values for the
// dual channel register decoder; definitions only, no logic.
`ifndef DRD_REG_MAP_VH
`define DRD_REG_MAP_VH

// wishbone byte offsets
`define DRD_OFS_ADDR      8'h00
`define DRD_OFS_DATA      8'h04
`define DRD_OFS_CTRL      8'h08

// channel select values
`define DRD_CH_A          1'b1
`define DRD_CH_B          1'b0

// address line positions
`define DRD_AD_CHAN_HI    5
`define DRD_AD_CHAN_LO    0
`define DRD_AD_IDX_MSB    4
`define DRD_AD_IDX_LSB    1

// register indices
`define DRD_IDX_CMD       4'h0
`define DRD_IDX_VEC       4'h2
`define DRD_IDX_RXPAR     4'h3
`define DRD_IDX_MODE4     4'h4
`define DRD_IDX_MODE5     4'h5
`define DRD_IDX_CNTLO     4'h6
`define DRD_IDX_CNTHI     4'h7
`define DRD_IDX_TXBUF     4'h8
`define DRD_IDX_MIC       4'h9
`define DRD_IDX_MISC      4'hA
`define DRD_IDX_ALT11     4'hB
`define DRD_IDX_TCHI      4'hD
`define DRD_IDX_OPTRD     4'hE
`define DRD_IDX_EXTST     4'hF
`define DRD_IDX_IMG_OFS   4'h4

// bit positions
`define DRD_BIT_OPT_GATE  0
`define DRD_BIT_FIFO_EN   2
`define DRD_BIT_XRD_EN    6
`define DRD_CMD_MSB       1
`define DRD_CMD_LSB       0

// decoding mode command codes in the channel B command register
`define DRD_CMD_LOWCH     2'h1
`define DRD_CMD_HIGHCH    2'h2

// control/status word fields
`define DRD_CTL_MODE      0
`define DRD_CTL_CHAN      1
`define DRD_CTL_IDX_LSB   2
`define DRD_CTL_IDX_MSB   5
`define DRD_CTL_FIFO      6
`define DRD_CTL_XRD       7

// reset values
`define DRD_RST_BYTE      8'h00
`define DRD_RST_WORD      32'h0000_0000
`define DRD_RST_IDX       4'h0
`define DRD_RST_MODE      1'b1

`endif

// ==== drd_reg_mem.v ====
// register storage: 32 bytes, one per channel and register index.
// assumes a single clock; read data leaves through a register.
`timescale 1ns/100ps
`include "drd_reg_map.vh"

module drd_reg_mem (
  // clock and reset
  input  wire       mclk,
  input  wire       rst_n,
  // write port
  input  wire       wrEn,
  input  wire [4:0] wrAddr,
  input  wire [7:0] wrData,
  // read port
  input  wire [4:0] rdAddr,
  output reg  [7:0] rdData_ff
);

  reg [7:0] store [0:31];

  always @(posedge mclk) begin
    if (wrEn) begin
      store[wrAddr] <= wrData;
    end
  end

  // array itself is not reset; software initialises before reading back
  always @(posedge mclk) begin
    if (!rst_n) begin
      rdData_ff <= `DRD_RST_BYTE;
    end else begin
      rdData_ff <= store[rdAddr];
    end
  end

endmodule

// ==== test_dual_channel_register_decoder.sv ====
// self-checking bench for the register decoder, random and corner cases.
// assumes channel logic answers with a pattern of its chan and index.
`timescale 1ns/100ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin error_cnt++; \
  $display("BAD t=%0t got %h exp %h", $time, g, e); end end
module test_dual_channel_register_decoder;
  reg         mclk = 1'b0;
  reg         rst_n = 1'b0;
  reg  [7:0]  wbAdr = 8'h00;
  reg  [31:0] wbDat = 32'h0;
  reg         wbWe = 1'b0;
  reg         wbReq = 1'b0;
  reg  [3:0]  wbSel = 4'h1;
  reg         go = 1'b0;
  reg  [7:0]  goAddr = 8'h00;
  reg  [15:0] lfsr = 16'h737A;
  reg  [7:0]  rd, v, w4, w5, w3, wa, op;
  integer     error_cnt = 0;
  integer     checked = 0;
  integer     txCnt = 0;
  integer     i;
  wire [31:0] wbDatO;
  wire        ack, sChan, txStb, txChan, mode, strobeN;
  wire [3:0]  sIdx;
  wire [7:0]  txData, bus;
  wire [1:0]  fifoEn, xrdEn;
  wire [7:0]  sData = {sChan, 3'h5, sIdx};

  always #25 mclk = ~mclk;
  // counts transmit hand-off pulses as the design shows them
  always @(posedge mclk) begin
    if (txStb === 1'b1) txCnt <= txCnt + 1;
  end
  drd_cpu_model CPU (.mclk(mclk), .go(go), .addrIn(goAddr), .muxAddrDataBus(bus),
    .addressStrobeN(strobeN));
  drd_reg_decoder DUT (.mclk(mclk), .rst_n(rst_n), .muxAddrDataBus(bus),
    .addressStrobeN(strobeN), .wb_adr_i(wbAdr), .wb_dat_i(wbDat), .wb_dat_o(wbDatO),
    .wb_we_i(wbWe), .wb_sel_i(wbSel), .wb_stb_i(wbReq), .wb_cyc_i(wbReq), .wb_ack_o(ack),
    .statusRdChan(sChan), .statusRdIdx(sIdx), .statusRdData(sData), .txStrobe(txStb),
    .txChan(txChan), .txData(txData), .shiftLeftMode(mode), .statusFifoEnable(fifoEn),
    .extReadEnable(xrdEn));

  function [15:0] nxt_lfsr(input [15:0] s);
    nxt_lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function [7:0] st(input c, input [3:0] x);
    st = {c, 3'h5, x};
  endfunction
  task give_verdict;
    begin
      $display("checks %0d errors %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask
  task wb(input we, input [7:0] adr, input [7:0] d);
    integer n;
    begin
      wbReq <= 1'b1;
      wbWe <= we;
      wbAdr <= adr;
      wbDat <= {24'h0, d};
      n = 0;
      do begin @(posedge mclk); n = n + 1; end while (ack !== 1'b1 && n < 20);
      rd = wbDatO[7:0];
      if (ack !== 1'b1) begin error_cnt++; give_verdict; end
      wbReq <= 1'b0;
      @(posedge mclk);
    end
  endtask
  task strobe(input [7:0] a);
    begin
      go <= 1'b1;
      goAddr <= a;
      @(posedge mclk);
      go <= 1'b0;
      repeat (4) @(posedge mclk);
    end
  endtask
  // high-channel-bit addressing, one channel at a time
  task wr(input c, input [3:0] x, input [7:0] d);
    begin strobe({2'b00, c, x, 1'b0}); wb(1'b1, 8'h04, d); end
  endtask
  task rdc(input c, input [3:0] x, input [7:0] e);
    begin strobe({2'b00, c, x, 1'b0}); wb(1'b0, 8'h04, 8'h00); `CHK(rd, e) end
  endtask

  initial begin
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    wb(1'b0, 8'h08, 8'h00);
    `CHK(rd, 8'h01)
    for (i = 0; i < 24; i = i + 1) begin
      lfsr = nxt_lfsr(lfsr);
      v = lfsr[7:0];
      if (i == 12) wr(1'b0, 4'h0, 8'h01);
      strobe(v);
      wb(1'b0, 8'h00, 8'h00);
      `CHK(rd, v)
      wb(1'b0, 8'h08, 8'h00);
      `CHK(rd[5:0], i < 12 ? {v[4:1], v[5], 1'b1} : {v[4:1], v[0], 1'b0})
    end
    for (i = 0; i < 2; i = i + 1) begin
      strobe(8'h10 + i[7:0]); // same value at consecutive addresses
      wb(1'b1, 8'h04, 8'hC3);
      @(posedge mclk);
      `CHK({txChan, txData}, {i[0], 8'hC3})
      `CHK(txCnt, i + 1)
    end
    strobe(8'h00);
    wb(1'b1, 8'h04, 8'h02);
    wb(1'b0, 8'h08, 8'h00);
    `CHK(rd, 8'h01)
    wb(1'b1, 8'h04, 8'h03);
    `CHK(mode, 1'b1)
    wbSel <= 4'h0;
    wb(1'b1, 8'h04, 8'h01);
    wbSel <= 4'h1;
    `CHK(mode, 1'b1)
    wr(1'b1, 4'h0, 8'h01);
    `CHK(mode, 1'b1)
    lfsr = nxt_lfsr(lfsr);
    {w5, w4} = lfsr;
    lfsr = nxt_lfsr(lfsr);
    {wa, w3} = lfsr;
    op = w3 | 8'h40;
    wr(1'b1, 4'h4, w4);
    wr(1'b1, 4'h5, w5);
    wr(1'b1, 4'h3, w3);
    wr(1'b1, 4'hA, wa);
    wr(1'b1, 4'h7, op);
    wr(1'b1, 4'hF, 8'h05);
    `CHK({fifoEn, xrdEn}, 4'h8)
    rdc(1'b1, 4'hE, st(1'b1, 4'hE));
    wr(1'b1, 4'h7, op);
    `CHK(xrdEn, 2'h2)
    rdc(1'b1, 4'h4, w4);
    rdc(1'b1, 4'h5, w5);
    rdc(1'b1, 4'h9, w3);
    rdc(1'b1, 4'hB, wa);
    rdc(1'b1, 4'hE, op);
    rdc(1'b1, 4'h6, st(1'b1, 4'h6));
    rdc(1'b1, 4'h7, st(1'b1, 4'h7));
    rdc(1'b0, 4'h4, st(1'b0, 4'h0));
    wr(1'b1, 4'hF, 8'h00);
    `CHK(fifoEn, 2'h0)
    for (i = 4; i < 8; i = i + 1)
      rdc(1'b1, i[3:0], st(1'b1, i[3:0] - 4'h4));
    rdc(1'b1, 4'h9, st(1'b1, 4'hD));
    rdc(1'b1, 4'hB, st(1'b1, 4'hF));
    wb(1'b0, 8'h0C, 8'h00);
    `CHK(rd, 8'h00)
    wr(1'b0, 4'h0, 8'h01);
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    wb(1'b0, 8'h08, 8'h00);
    `CHK(rd, 8'h01)
    `CHK({mode, fifoEn, xrdEn}, 5'h10)
    give_verdict;
  end
endmodule

bind drd_reg_decoder drd_reg_decoder_props u_props (.mclk(mclk), .rst_n(rst_n),
  .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_we_i(wb_we_i), .wb_stb_i(wb_stb_i),
  .wb_cyc_i(wb_cyc_i), .wb_ack_o(wb_ack_o), .txStrobe(txStrobe),
  .shiftLeftMode(shiftLeftMode), .statusFifoEnable(statusFifoEnable),
  .extReadEnable(extReadEnable));
